// >>> bench/flsq_link_chk.sv
`timescale 1ns/10ps
module flsq_link_chk (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io,
  input wire logic [3:0] host_io_oe_n,
  input wire logic [3:0] dev_io,
  input wire logic [3:0] dev_io_oe_n,
  input wire logic [3:0] io
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_sclk_idle: assert property (cs_n |-> !sclk) else $error("clock outside frame");
  a_high_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("high");
  a_low_half: assert property ($fell(sclk) |-> !sclk[*4]) else $error("low phase short");
  a_sel_gap: assert property ($rose(cs_n) |-> cs_n[*4]) else $error("select gap short");
  a_data_hold: assert property (sclk && $past(sclk) |-> $stable(host_io)) else $error("d");
  a_dev_quiet: assert property (cs_n[*4] |-> &dev_io_oe_n) else $error("device drives");
  a_dev_line: assert property (dev_io_oe_n[3:2] == 2'b11 && dev_io_oe_n[0]) else $error("l");
  a_no_clash: assert property ((host_io_oe_n | dev_io_oe_n) == 4'hf) else $error("clash");
  c_frame: cover property ($rose(cs_n));
  c_status: cover property (!dev_io_oe_n[1] && io[1] == dev_io[1]);
  c_quad: cover property (!host_io_oe_n[3]);
endmodule : flsq_link_chk

// >>> bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import flsq_pkg::*;
  logic        clock_i, rst_i, psel, penable, pwrite, pready, pslverr, err, qe, busy, write_enable_latch;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lock, rd_addr;
  logic        pcmp, psmall, ptb;
  logic [2:0]  pbits;
  logic [7:0]  rd_data;
  int          num_errors, comparisons;
  flsq_link_if link ();
  flsq_host flsq_host_inst (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .link(link));
  // Short timers: the walk over an erase region still sets the real busy length.
  flsq_device #(.PROGRAM_CYCLES(300), .UNIT4K_CYCLES(300), .HALF_CYCLES(300),
    .FULL_CYCLES(300), .DEVICE_CYCLES(300)) flsq_device_inst (.clock_i(clock_i),
    .rst_i(rst_i), .link(link), .quad_enable_bit_i(qe), .protect_complement_i(pcmp),
    .small_unit_protect_i(psmall), .top_bottom_select_i(ptb), .protect_range_bits_i(pbits),
    .sector_lock_i(lock), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .busy_o(busy),
    .write_enable_latch_o(write_enable_latch));
  flsq_link_chk flsq_link_chk_inst (.clock_i(clock_i), .rst_i(rst_i), .cs_n(link.cs_n),
    .sclk(link.sclk), .host_io(link.host_io), .host_io_oe_n(link.host_io_oe_n),
    .dev_io(link.dev_io), .dev_io_oe_n(link.dev_io_oe_n), .io(link.io));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_i) penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Frames are launched only once the host reports idle, since it drops busy-time writes.
  task automatic run(logic [31:0] c, logic [23:0] a, logic [31:0] d);
    apb(1'b1, OFF_ADDR, {8'h00, a});
    apb(1'b1, OFF_WDATA, d);
    apb(1'b1, OFF_CTRL, c | 32'h8000_0000);
    do apb(1'b0, OFF_STAT, 32'h0); while (rd[0] !== 1'b0);
  endtask : run
  task automatic done(logic e);
    repeat (8) @(posedge clock_i);
    chk("busy", busy, e);
    while (busy === 1'b1) @(posedge clock_i);
  endtask : done
  task automatic mem(logic [15:0] a, logic [7:0] e);
    @(posedge clock_i) rd_addr <= a;
    repeat (2) @(posedge clock_i);
    chk("array byte", rd_data, e);
  endtask : mem
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    #2400000;
    num_errors++;
    end_of_test();
  end
  initial begin
    rst_i = 1'b1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    qe = 0; lock = 0; rd_addr = 0; num_errors = 0; comparisons = 0;
    pcmp = 0; psmall = 0; ptb = 0; pbits = 0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", err, 1'b1);
    run(32'h06, 0, 0);
    run(32'h902, 24'h0000fe, 32'h44332211);
    done(1'b1);
    chk("latch", write_enable_latch, 1'b0);
    mem(16'h00ff, 8'h22);
    mem(16'h0000, 8'h33);
    mem(16'h0002, 8'hff);
    run(32'h302, 24'h000100, 32'h55);
    done(1'b0);
    mem(16'h0100, 8'hff);
    run(32'h06, 0, 0);
    run(32'h1932, 24'h001000, 32'h44332211);
    done(1'b0);
    qe <= 1'b1;
    run(32'h1932, 24'h001000, 32'h44332211);
    done(1'b1);
    mem(16'h1003, 8'h44);
    $display("program tests done");
    run(32'h06, 0, 0);
    run(32'h30302, 24'h000300, 32'h66);
    done(1'b0);
    lock <= 16'h0002;
    run(32'h152, 24'h001000, 0);
    done(1'b0);
    run(32'hc7, 0, 0);
    done(1'b0);
    ptb <= 1'b1;
    pbits <= 3'h1;
    run(32'h120, 24'h000010, 0);
    done(1'b0);
    ptb <= 1'b0;
    pbits <= 3'h0;
    lock <= 16'h0000;
    run(32'h120, 24'h000010, 0);
    done(1'b1);
    mem(16'h00ff, 8'hff);
    mem(16'h1000, 8'h11);
    run(32'h60, 0, 0);
    done(1'b0);
    run(32'h06, 0, 0);
    run(32'h1d8, 24'h001234, 0);
    run(32'h902, 24'h002000, 32'h0);
    run(32'h2005, 0, 0);
    chk("status byte", rd[15:8], 8'h03);
    done(1'b1);
    mem(16'h1000, 8'hff);
    mem(16'h2000, 8'hff);
    $display("erase tests done");
    end_of_test();
  end
endmodule : tb_top

// >>> verilog/flsq_device.sv
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
module flsq_device
  import flsq_pkg::*;
#(
  parameter int MEM_AW         = 16,
  parameter int PROGRAM_CYCLES = PROGRAM_CYC,
  parameter int UNIT4K_CYCLES  = UNIT4K_CYC,
  parameter int HALF_CYCLES    = HALF_BLOCK_CYC,
  parameter int FULL_CYCLES    = FULL_BLOCK_CYC,
  parameter int DEVICE_CYCLES  = DEVICE_CYC
)(
  input  wire logic                              clock_i,
  input  wire logic                              rst_i,
  flsq_link_if.dev                               link,
  input  wire logic                              quad_enable_bit_i,
  input  wire logic                              protect_complement_i,
  input  wire logic                              small_unit_protect_i,
  input  wire logic                              top_bottom_select_i,
  input  wire logic [2:0]                        protect_range_bits_i,
  input  wire logic [2**(MEM_AW-UNIT_AW)-1:0]    sector_lock_i,
  input  wire logic [MEM_AW-1:0]                 rd_addr_i,
  output logic      [7:0]                        rd_data_o,
  output logic                                   busy_o,
  output logic                                   write_enable_latch_o
);
  localparam int MEM_BYTES = 2**MEM_AW;

  if (MEM_AW < FULL_AW || MEM_AW > ADDR_BITS) begin : g_bad_aw
    $error("flsq_device: MEM_AW must lie between 16 and 24.");
  end
  if (PROGRAM_CYCLES < 1 || UNIT4K_CYCLES < 1 || HALF_CYCLES < 1 ||
      FULL_CYCLES < 1 || DEVICE_CYCLES < 1) begin : g_bad_time
    $error("flsq_device: every cycle count must be at least one.");
  end

  // ---------------------------------------------------------------
  // Link sampling
  // ---------------------------------------------------------------
  logic [5:0] pin_s;
  logic [5:0] pin_r;
  logic [5:0] pin_f;

  flsq_pin_sync #(.WIDTH(6), .RESET_VAL(6'h2f)) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   ({link.cs_n, link.sclk, link.io}),
    .level_o (pin_s),
    .rise_o  (pin_r),
    .fall_o  (pin_f)
  );

  logic frame;
  logic clk_up;
  logic clk_dn;
  logic cs_up;
  logic cs_dn;
  assign frame  = ~pin_s[5];
  assign clk_up = pin_r[4] & frame;
  assign clk_dn = pin_f[4] & frame;
  assign cs_up  = pin_r[5];
  assign cs_dn  = pin_f[5];

  // ---------------------------------------------------------------
  // Command shifter
  // ---------------------------------------------------------------
  logic [7:0]  sh;
  logic [2:0]  bcnt;
  logic [3:0]  nbyte;
  logic [7:0]  opcode;
  logic [23:0] addr;
  logic [7:0]  ptr;
  logic [7:0]  next_sh;
  logic [2:0]  next_bcnt;
  logic        quad_phase;
  logic        byte_done;
  logic        data_ok;
  flsq_walk_t  state;
  logic        busy;

  assign busy       = state != FLSQ_WK_IDLE;
  assign quad_phase = opcode == OP_QUAD_PROG && nbyte >= 4'd4;

  always_comb begin
    next_sh   = quad_phase ? {sh[3:0], pin_s[3:0]} : {sh[6:0], pin_s[0]};  // R13
    next_bcnt = bcnt + (quad_phase ? 3'd4 : 3'd1);
  end

  assign byte_done = clk_up && next_bcnt == 3'd0;
  assign data_ok   = byte_done && nbyte >= 4'd4 && !busy &&
                     (opcode == OP_PAGE_PROG || opcode == OP_QUAD_PROG);  // R22

  always_ff @(posedge clock_i) begin
    if (rst_i || cs_dn) begin
      sh    <= 8'h00;
      bcnt  <= 3'd0;
      nbyte <= 4'd0;
    end else if (clk_up) begin
      sh   <= next_sh;
      bcnt <= next_bcnt;
      if (byte_done && nbyte != 4'hf) begin
        nbyte <= nbyte + 4'd1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      opcode <= 8'h00;
      addr   <= 24'h000000;
      ptr    <= 8'h00;
    end else if (byte_done) begin
      case (nbyte)
        4'd0: opcode <= next_sh;  // R1
        4'd1, 4'd2: addr <= {addr[15:0], next_sh};
        4'd3: begin
          addr <= {addr[15:0], next_sh};
          ptr  <= next_sh;
        end
        default: if (data_ok) ptr <= ptr + 8'd1;  // R4
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Page buffer
  // ---------------------------------------------------------------
  // A fresh valid mask per frame keeps untouched bytes of the page as they were.
  logic [7:0]   page_buf [0:2**PAGE_AW-1];
  logic [255:0] buf_vld;

  always_ff @(posedge clock_i) begin
    if (data_ok) begin
      page_buf[ptr] <= next_sh;  // R5
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || (cs_dn && !busy)) begin
      buf_vld <= '0;
    end else if (data_ok) begin
      buf_vld[ptr] <= 1'b1;  // R6
    end
  end

  // ---------------------------------------------------------------
  // Protection
  // ---------------------------------------------------------------
  function automatic logic [MEM_AW:0] prot_span();
    int s;
    s = small_unit_protect_i ? 2**UNIT_AW : MEM_BYTES / 64;
    case (protect_range_bits_i)
      3'd0:    s = 0;
      3'd7:    s = MEM_BYTES;
      default: s = s << (protect_range_bits_i - 3'd1);
    endcase
    if (s > MEM_BYTES) begin
      s = MEM_BYTES;
    end
    return (MEM_AW+1)'(s);
  endfunction : prot_span

  function automatic logic prot_hit(input logic [MEM_AW-1:0] a);
    logic [MEM_AW-1:0] off;
    logic              in_span;
    off     = top_bottom_select_i ? a : ~a;
    in_span = {1'b0, off} < prot_span();
    return (protect_complement_i ? !in_span : in_span) ||
           sector_lock_i[a[MEM_AW-1:UNIT_AW]];
  endfunction : prot_hit

  // A process, not an assign, so that every protection input retriggers the span.
  logic any_prot;
  always_comb begin
    any_prot = (protect_complement_i ? prot_span() != (MEM_AW+1)'(MEM_BYTES)
                                     : prot_span() != '0) || |sector_lock_i;
  end

  // ---------------------------------------------------------------
  // Command decision at select release
  // ---------------------------------------------------------------
  logic              cmd_ok;
  logic              go;
  logic              wel_set;
  logic              write_enable_latch;
  logic [MEM_AW-1:0] mask;
  logic [31:0]       next_time;
  flsq_walk_t        next_mode;

  always_comb begin
    cmd_ok    = 1'b0;
    mask      = '1;
    next_time = 32'(DEVICE_CYCLES - 1);
    next_mode = FLSQ_WK_WIPE;
    case (opcode)
      OP_PAGE_PROG, OP_QUAD_PROG: begin
        cmd_ok    = nbyte >= 4'd5 && !prot_hit(addr[MEM_AW-1:0]) &&  // R2 R11
                    (opcode != OP_QUAD_PROG || quad_enable_bit_i);    // R12
        mask      = MEM_AW'(2**PAGE_AW - 1);
        next_time = 32'(PROGRAM_CYCLES - 1);
        next_mode = FLSQ_WK_PROG;
      end
      OP_UNIT_WIPE: begin
        cmd_ok    = nbyte == 4'd4 && !prot_hit(addr[MEM_AW-1:0]);  // R14
        mask      = MEM_AW'(2**UNIT_AW - 1);
        next_time = 32'(UNIT4K_CYCLES - 1);
      end
      OP_HALF_WIPE: begin
        cmd_ok    = nbyte == 4'd4 && !prot_hit(addr[MEM_AW-1:0]);  // R15
        mask      = MEM_AW'(2**HALF_AW - 1);
        next_time = 32'(HALF_CYCLES - 1);
      end
      OP_FULL_WIPE: begin
        cmd_ok    = nbyte == 4'd4 && !prot_hit(addr[MEM_AW-1:0]);  // R16
        mask      = MEM_AW'(2**FULL_AW - 1);
        next_time = 32'(FULL_CYCLES - 1);
      end
      OP_ALL_WIPE_A, OP_ALL_WIPE_B: begin
        cmd_ok = nbyte == 4'd1 && !any_prot;  // R17 R18
      end
      default: cmd_ok = 1'b0;
    endcase
  end

  // A partial last byte, a cleared latch or a running cycle starts nothing.
  assign go      = cs_up && !busy && write_enable_latch && bcnt == 3'd0 && cmd_ok;  // R3 R7 R22 R23
  assign wel_set = cs_up && !busy && opcode == OP_WRITE_EN && nbyte == 4'd1 && bcnt == 3'd0;

  // ---------------------------------------------------------------
  // Self-timed cycle
  // ---------------------------------------------------------------
  // Busy lasts for the longer of the timer and the array walk.
  logic [31:0]       timer;
  logic [MEM_AW-1:0] wk;
  logic [MEM_AW-1:0] wk_base;
  logic [MEM_AW-1:0] wk_last;
  logic [MEM_AW-1:0] mem_wa;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state   <= FLSQ_WK_IDLE;
      timer   <= 32'h0;
      wk      <= '0;
      wk_base <= '0;
      wk_last <= '0;
    end else begin
      if (timer != 32'h0) begin
        timer <= timer - 32'h1;
      end
      case (state)
        FLSQ_WK_IDLE: if (go) begin
          state   <= next_mode;  // R8
          timer   <= next_time;
          wk      <= '0;
          wk_base <= addr[MEM_AW-1:0] & ~mask;  // R21
          wk_last <= mask;
        end
        FLSQ_WK_PROG, FLSQ_WK_WIPE: begin
          wk <= wk + MEM_AW'(1);
          if (wk == wk_last) begin
            state <= FLSQ_WK_WAIT;
          end
        end
        FLSQ_WK_WAIT: if (timer == 32'h0) state <= FLSQ_WK_IDLE;
        default: state <= FLSQ_WK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      write_enable_latch <= 1'b0;
    end else if (wel_set) begin
      write_enable_latch <= 1'b1;
    end else if (state == FLSQ_WK_WAIT && timer == 32'h0) begin
      write_enable_latch <= 1'b0;  // R10
    end
  end

  // ---------------------------------------------------------------
  // Array
  // ---------------------------------------------------------------
  // Programming can only clear bits, so unerased targets keep stray zeros.
  logic [7:0] mem [0:MEM_BYTES-1] = '{default: ERASED_BYTE};

  assign mem_wa = wk_base | wk;

  always_ff @(posedge clock_i) begin
    if (state == FLSQ_WK_PROG && buf_vld[wk[7:0]]) begin
      mem[mem_wa] <= mem[mem_wa] & page_buf[wk[7:0]];  // R6
    end else if (state == FLSQ_WK_WIPE) begin
      mem[mem_wa] <= ERASED_BYTE;  // R14 R15 R16 R17
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

  // ---------------------------------------------------------------
  // Status answer
  // ---------------------------------------------------------------
  logic [2:0] obit;
  logic       dev_do;
  logic [7:0] status;
  logic       rd_active;

  always_comb begin
    status          = 8'h00;
    status[ST_BUSY] = busy;
    status[ST_WEL]  = write_enable_latch;
  end

  assign rd_active = frame && opcode == OP_READ_STAT && nbyte != 4'd0;

  always_ff @(posedge clock_i) begin
    if (rst_i || cs_dn) begin
      obit   <= 3'd0;
      dev_do <= 1'b0;
    end else if (clk_dn && nbyte != 4'd0) begin
      dev_do <= status[~obit];  // R9
      obit   <= obit + 3'd1;
    end
  end

  assign link.dev_io       = {2'b00, dev_do, 1'b0};
  assign link.dev_io_oe_n  = rd_active ? 4'hd : 4'hf;
  assign busy_o            = busy;
  assign write_enable_latch_o = write_enable_latch;
endmodule : flsq_device

// >>> verilog/flsq_host.sv
`timescale 1ns/10ps
module flsq_host
  import flsq_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYC
)(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  flsq_link_if.host        link
);
  if (SCLK_HALF < 4 || SCLK_HALF > 255) begin : g_bad_half
    $error("flsq_host: SCLK_HALF must lie between 4 and 255.");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  flsq_host_t  state;
  logic [7:0]  c_op;
  logic        c_addr;
  logic [2:0]  c_nd;
  logic        c_quad;
  logic        c_read;
  logic [2:0]  c_extra;
  logic [23:0] c_adr;
  logic [31:0] c_wd;
  logic [7:0]  rdata;
  logic        idle;
  logic        access;
  logic        mapped;
  logic        launch;

  assign idle   = state == FLSQ_H_IDLE;
  assign access = psel_i && penable_i;
  assign mapped = paddr_i == OFF_CTRL || paddr_i == OFF_ADDR ||
                  paddr_i == OFF_WDATA || paddr_i == OFF_STAT;
  assign launch = access && pwrite_i && idle && paddr_i == OFF_CTRL &&
                  pwdata_i[CTRL_START_BIT];
  assign pready_o  = access;
  assign pslverr_o = access && !mapped;

  // Writes while a transfer runs are dropped so the frame stays coherent.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      c_op <= 8'h00;
      c_addr <= 1'b0;
      c_nd <= 3'd0;
      c_quad <= 1'b0;
      c_read <= 1'b0;
      c_extra <= 3'd0;
      c_adr <= 24'h0;
      c_wd <= 32'h0;
    end else if (access && pwrite_i && idle) begin
      case (paddr_i)
        OFF_CTRL: begin
          c_op    <= pwdata_i[CTRL_OP_LSB +: 8];
          c_addr  <= pwdata_i[CTRL_ADDR_BIT];  // R17
          c_nd    <= pwdata_i[CTRL_ND_LSB +: 3] > 3'd4 ? 3'd4 : pwdata_i[CTRL_ND_LSB +: 3];
          c_quad  <= pwdata_i[CTRL_QUAD_BIT];
          c_read  <= pwdata_i[CTRL_READ_BIT];
          c_extra <= pwdata_i[CTRL_EXTRA_LSB +: 3];
        end
        OFF_ADDR:  c_adr <= pwdata_i[23:0];
        OFF_WDATA: c_wd  <= pwdata_i;
        default:   c_wd  <= c_wd;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0;
    end else if (psel_i && !penable_i) begin
      case (paddr_i)
        OFF_CTRL:  prdata_o <= {13'h0000, c_extra, 2'b00, c_read, c_quad, c_nd, c_addr, c_op};
        OFF_ADDR:  prdata_o <= {8'h00, c_adr};
        OFF_WDATA: prdata_o <= c_wd;
        OFF_STAT:  prdata_o <= {16'h0, rdata, 7'h00, !idle};
        default:   prdata_o <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  logic [6:0]  n_ser;
  logic [6:0]  n_quad;
  logic [6:0]  total;
  logic [6:0]  k;
  logic [63:0] sh;
  logic [7:0]  tmr;
  logic [31:0] wb;
  logic        in_quad;
  logic        in_read;
  logic        io1_s;

  assign n_ser  = 7'd8 + (c_addr ? 7'd24 : 7'd0) + (c_quad ? 7'd0 : {1'b0, c_nd, 3'b000}) +
                  {4'h0, c_extra};  // R1 R7
  assign n_quad = c_quad ? {3'b000, c_nd, 1'b0} : 7'd0;  // R13
  assign total  = n_ser + n_quad + (c_read ? 7'd8 : 7'd0);
  assign in_quad = k >= n_ser && k < n_ser + n_quad;
  assign in_read = k >= n_ser + n_quad;
  assign wb      = {c_wd[7:0], c_wd[15:8], c_wd[23:16], c_wd[31:24]};

  flsq_pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (link.io[1]),
    .level_o (io1_s),
    .rise_o  (),
    .fall_o  ()
  );

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state     <= FLSQ_H_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      k         <= 7'd0;
      sh        <= 64'h0;
      tmr       <= 8'h00;
      rdata     <= 8'h00;
    end else begin
      tmr <= tmr - 8'h01;
      case (state)
        FLSQ_H_IDLE: if (launch) state <= FLSQ_H_LOAD;
        FLSQ_H_LOAD: begin
          sh        <= c_addr ? {c_op, c_adr, wb} : {c_op, wb, 24'h0};
          k         <= 7'd0;
          link.cs_n <= 1'b0;  // R19
          tmr       <= 8'(SCLK_HALF - 1);
          state     <= FLSQ_H_LOW;
        end
        FLSQ_H_LOW: if (tmr == 8'h00) begin
          link.sclk <= 1'b1;
          tmr       <= 8'(SCLK_HALF - 1);
          state     <= FLSQ_H_HIGH;
        end
        FLSQ_H_HIGH: if (tmr == 8'h00) begin
          if (in_read) begin
            rdata <= {rdata[6:0], io1_s};
          end
          sh        <= in_quad ? {sh[59:0], 4'h0} : {sh[62:0], 1'b0};
          k         <= k + 7'd1;
          link.sclk <= 1'b0;
          tmr       <= 8'(SCLK_HALF - 1);
          state     <= k + 7'd1 == total ? FLSQ_H_END : FLSQ_H_LOW;
        end
        FLSQ_H_END: if (tmr == 8'h00) begin
          link.cs_n <= 1'b1;  // R7
          tmr       <= 8'(SCLK_HALF - 1);
          state     <= FLSQ_H_GAP;
        end
        FLSQ_H_GAP: if (tmr == 8'h00) state <= FLSQ_H_IDLE;
        default: state <= FLSQ_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      link.host_io      <= 4'h0;
      link.host_io_oe_n <= 4'hf;
    end else begin
      link.host_io <= in_quad ? sh[63:60] : {3'b000, sh[63]};
      if (state != FLSQ_H_LOW && state != FLSQ_H_HIGH || in_read) begin
        link.host_io_oe_n <= 4'hf;
      end else begin
        link.host_io_oe_n <= in_quad ? 4'h0 : 4'he;  // R13
      end
    end
  end
endmodule : flsq_host

// >>> verilog/flsq_link_if.sv
`timescale 1ns/10ps
interface flsq_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io;
  logic [3:0] host_io_oe_n;
  logic [3:0] dev_io;
  logic [3:0] dev_io_oe_n;
  logic [3:0] io;

  // Undriven lines float high, as with a pull-up on the board.
  for (genvar i = 0; i < 4; i++) begin : g_wire
    assign io[i] = !dev_io_oe_n[i] ? dev_io[i] : (!host_io_oe_n[i] ? host_io[i] : 1'b1);
  end

  modport host (output cs_n, sclk, host_io, host_io_oe_n, input io);
  modport dev  (input cs_n, sclk, io, output dev_io, dev_io_oe_n);
endinterface : flsq_link_if

// >>> verilog/flsq_pin_sync.sv
`timescale 1ns/10ps
module flsq_pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);
  if (WIDTH < 1) begin : g_bad_width
    $error("flsq_pin_sync: WIDTH must be at least one.");
  end

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] lvl;
  logic [WIDTH-1:0] prev;

  // Only the second stage and its delayed copy feed the edge logic.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta <= RESET_VAL;
      lvl  <= RESET_VAL;
      prev <= RESET_VAL;
    end else begin
      meta <= pin_i;
      lvl  <= meta;
      prev <= lvl;
    end
  end

  assign level_o = lvl;
  assign rise_o  = lvl & ~prev;
  assign fall_o  = ~lvl & prev;
endmodule : flsq_pin_sync

// >>> verilog/flsq_pkg.sv
// How it works
// R1: Page program: opcode 02h, 24-bit address, data.
// R2: One to 256 bytes per program.
// R3: Program and erase need write enable latch set.
// R4: Only low 8 address bits advance, wrapping.
// R5: Over 256 bytes: later bytes overwrite earlier.
// R6: Partial program leaves other page bytes unchanged.
// R7: Select must rise on a byte boundary.
// R8: Valid program starts timed busy cycle.
// R9: Status read still answered while busy.
// R10: Cycle end clears write enable latch.
// R11: Protected address refuses program or erase.
// R12: Quad program needs quad enable bit.
// R13: Quad program 32h sends data on four lines.
// R14: 20h erases aligned 4 KB sector.
// R15: 52h erases aligned 32 KB block.
// R16: D8h erases aligned 64 KB block.
// R17: C7h or 60h erase all, 8 bits.
// R18: Whole erase refused if anything protected.
// R19: Host holds select low for whole command.
// R20: Host programs only erased locations.
// R21: Erase ignores address bits below region size.
// R22: Commands while busy are ignored.
// R23: Refused command leaves busy at zero.
package flsq_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 25;
  localparam int LINK_PERIOD_NS         = 200;
  localparam int SCLK_HALF_CYC          = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam int PROGRAM_TIME_US        = 1000;
  localparam int UNIT4K_WIPE_TIME_US    = 50000;
  localparam int HALF_BLOCK_WIPE_TIME_US = 100000;
  localparam int FULL_BLOCK_WIPE_TIME_US = 150000;
  localparam int DEVICE_WIPE_TIME_US    = 1000000;
  localparam int PROGRAM_CYC    = PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int UNIT4K_CYC     = UNIT4K_WIPE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int HALF_BLOCK_CYC = HALF_BLOCK_WIPE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int FULL_BLOCK_CYC = FULL_BLOCK_WIPE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int DEVICE_CYC     = DEVICE_WIPE_TIME_US * 1000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Commands and geometry
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG  = 8'h32;
  localparam logic [7:0] OP_UNIT_WIPE  = 8'h20;
  localparam logic [7:0] OP_HALF_WIPE  = 8'h52;
  localparam logic [7:0] OP_FULL_WIPE  = 8'hd8;
  localparam logic [7:0] OP_ALL_WIPE_A = 8'hc7;
  localparam logic [7:0] OP_ALL_WIPE_B = 8'h60;
  localparam logic [7:0] OP_WRITE_EN   = 8'h06;
  localparam logic [7:0] OP_READ_STAT  = 8'h05;
  localparam logic [7:0] ERASED_BYTE   = 8'hff;
  localparam int ADDR_BITS = 24;
  localparam int PAGE_AW   = 8;
  localparam int UNIT_AW   = 12;
  localparam int HALF_AW   = 15;
  localparam int FULL_AW   = 16;
  localparam int ST_BUSY   = 0;
  localparam int ST_WEL    = 1;

  // ---------------------------------------------------------------
  // Host register map
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL  = 12'h000;
  localparam logic [11:0] OFF_ADDR  = 12'h004;
  localparam logic [11:0] OFF_WDATA = 12'h008;
  localparam logic [11:0] OFF_STAT  = 12'h00c;
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_ADDR_BIT  = 8;
  localparam int CTRL_ND_LSB    = 9;
  localparam int CTRL_QUAD_BIT  = 12;
  localparam int CTRL_READ_BIT  = 13;
  localparam int CTRL_EXTRA_LSB = 16;
  localparam int CTRL_START_BIT = 31;
  localparam int STAT_RD_LSB    = 8;

  typedef enum logic [1:0] {
    FLSQ_WK_IDLE = 2'b00,
    FLSQ_WK_PROG = 2'b01,
    FLSQ_WK_WIPE = 2'b10,
    FLSQ_WK_WAIT = 2'b11
  } flsq_walk_t;

  typedef enum logic [2:0] {
    FLSQ_H_IDLE = 3'b000,
    FLSQ_H_LOAD = 3'b001,
    FLSQ_H_LOW  = 3'b010,
    FLSQ_H_HIGH = 3'b011,
    FLSQ_H_END  = 3'b100,
    FLSQ_H_GAP  = 3'b101
  } flsq_host_t;

endpackage : flsq_pkg
